// ==== pcs_config_status_control.sv ====
/*
 * Coding-sublayer configuration and status register for one port, with
 * the link qualification it steers and the datapath controls it drives.
 * Assumes a management front end decodes page and address, and that the
 * fiber strap and line indications are asynchronous pins.
 */
// Summary of operation
// - Bits 15:12 and 4 ignore writes, read zero
// - Free-run bit selects free or aligned receive clock
// - True-quiet bit selects quiet transmit at 100M
// - Force bit asserts signal detect regardless of line
// - Policy set: lock raises link, signal holds it
// - Policy clear: signal or lock loss drops link
// - Timeout select: 2ms when set, 722us when clear
// - Fiber enable resets from strap, writable after
// - Force-good bit reports good 100M link
// - Far-end fault enable resets from fiber strap
// - Line-code bypass skips NRZI encode and decode
// - Scrambler skip resets from strap, skips scrambling
// - Descrambler skip resets from strap, skips descrambling
`timescale 1ns/1ns
`include "pcscs_consts.svh"

module pcs_config_status_control #(
	parameter int LONG_CYCLES = `PCSCS_TIMEOUT_LONG_US * `PCSCS_CLK_MHZ,
	parameter int SHORT_CYCLES = `PCSCS_TIMEOUT_SHORT_US * `PCSCS_CLK_MHZ
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clkEn,
	// Management access, already framed by the serial front end
	input wire logic [1:0] pageSel,
	input wire logic [4:0] regAddr,
	input wire logic wrStrobe,
	input wire logic [15:0] wrData,
	output logic [15:0] rdData,
	// Pins
	input wire logic fiberStrap,
	input wire logic signalLevelPin,
	input wire logic descramblerLockPin,
	// Datapath controls
	output logic rxClkFreeRun,
	output logic trueQuietTxEnable,
	output logic signalDetect,
	output logic fiberModeEnable,
	output logic farEndFaultEnable,
	output logic lineCodeBypass,
	output logic scramblerSkipEnable,
	output logic descramblerSkipEnable,
	output logic descramblerLongTimeout,
	output logic link100Good
);
	initial begin
		if (SHORT_CYCLES < 1 || LONG_CYCLES < SHORT_CYCLES)
			$error("pcs_config_status_control: bad timeout parameters");
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [2:0] syncA_reg, syncA_next;
	logic [2:0] syncB_reg, syncB_next;
	logic strapSeen;
	logic levelSync;
	logic lockSync;

	// Two stages per pin; only the second stage feeds logic
	always_comb begin
		syncA_next = {fiberStrap, signalLevelPin, descramblerLockPin};
		syncB_next = syncA_reg;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			syncA_reg <= 3'h0;
			syncB_reg <= 3'h0;
		end else if (clkEn) begin
			syncA_reg <= syncA_next;
			syncB_reg <= syncB_next;
		end
	end

	assign strapSeen = syncB_reg[2];
	assign levelSync = syncB_reg[1];
	assign lockSync = syncB_reg[0];

	// ****************************************
	// Strap capture after reset release
	// ****************************************
	// Async reset may only load constants, so the strap is folded in by a
	// load cycle once the synchroniser has settled after release.
	logic [1:0] loadWait_reg, loadWait_next;
	logic strapLoad;

	always_comb begin
		loadWait_next = loadWait_reg;
		if (loadWait_reg != `PCSCS_LOAD_DONE)
			loadWait_next = loadWait_reg + `PCSCS_LOAD_STEP;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			loadWait_reg <= 2'h0;
		else if (clkEn)
			loadWait_reg <= loadWait_next;
	end

	// Two edges pass first so the strap has crossed both synchroniser stages
	assign strapLoad = (loadWait_reg == `PCSCS_LOAD_AT);

	// ****************************************
	// Configuration register
	// ****************************************
	logic [15:0] cfg_reg, cfg_next;
	logic hit;

	// Reachable only on extended page 0 at its address
	assign hit = (pageSel == `PCSCS_PAGE_EXT0) && (regAddr == `PCSCS_REG_ADDR);

	// Software write wins over a simultaneous strap load; the load happens
	// once, two cycles after release, so the window is tiny.
	always_comb begin
		cfg_next = cfg_reg;
		if (strapLoad) begin
			if (strapSeen)
				cfg_next = cfg_reg | `PCSCS_STRAP_BITS;
			else
				cfg_next = cfg_reg & ~`PCSCS_STRAP_BITS;
		end
		if (wrStrobe && hit)
			cfg_next = wrData & `PCSCS_WR_MASK;
	end

	// Each instance is one port's private copy
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			cfg_reg <= `PCSCS_RESET_BASE;
		else if (clkEn)
			cfg_reg <= cfg_next;
	end

	// Reserved positions are never stored, so they read zero
	always_comb begin
		rdData = hit ? (cfg_reg & `PCSCS_WR_MASK) : 16'h0000;
	end

	// ****************************************
	// Descrambler sync watchdog
	// ****************************************
	logic syncLost;

	pcscs_sync_timer #(
		.LONG_CYCLES(LONG_CYCLES),
		.SHORT_CYCLES(SHORT_CYCLES)
	) uTimer (
		.clk(clk),
		.resetn(resetn),
		.clkEn(clkEn),
		.longSel(cfg_reg[`PCSCS_BIT_DESCRAMBLER_TIMEOUT_SELECT]),
		.syncSeen(lockSync),
		.syncLost(syncLost)
	);

	// ****************************************
	// Link qualification
	// ****************************************
	pcscs_pkg::pcscs_link_t link_reg, link_next;
	logic sdEff;
	logic locked;

	assign sdEff = cfg_reg[`PCSCS_BIT_SD_FORCE] | levelSync;
	// Descrambler skip means no lock to wait for, as in fiber mode
	assign locked = ~syncLost | cfg_reg[`PCSCS_BIT_DESCR_SKIP];

	always_comb begin
		link_next = link_reg;
		unique case (link_reg)
			pcscs_pkg::PCSCS_LINK_DOWN: begin
				if (cfg_reg[`PCSCS_BIT_FORCE_OK])
					link_next = pcscs_pkg::PCSCS_LINK_FORCED;
				else if (sdEff && locked)
					link_next = pcscs_pkg::PCSCS_LINK_UP;
			end
			pcscs_pkg::PCSCS_LINK_UP: begin
				if (cfg_reg[`PCSCS_BIT_FORCE_OK])
					link_next = pcscs_pkg::PCSCS_LINK_FORCED;
				else if (!sdEff)
					link_next = pcscs_pkg::PCSCS_LINK_DOWN;
				else if (!cfg_reg[`PCSCS_BIT_SD_POLICY] && !locked)
					link_next = pcscs_pkg::PCSCS_LINK_DOWN;
			end
			pcscs_pkg::PCSCS_LINK_FORCED: begin
				// Falls back to a fresh qualification when force clears
				if (!cfg_reg[`PCSCS_BIT_FORCE_OK])
					link_next = pcscs_pkg::PCSCS_LINK_DOWN;
			end
			default: link_next = pcscs_pkg::PCSCS_LINK_DOWN;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			link_reg <= pcscs_pkg::PCSCS_LINK_DOWN;
		else if (clkEn)
			link_reg <= link_next;
	end

	// ****************************************
	// Registered datapath controls
	// ****************************************
	logic [9:0] ctl_reg, ctl_next;

	always_comb begin
		ctl_next[0] = cfg_reg[`PCSCS_BIT_FREE_CLK];
		ctl_next[1] = cfg_reg[`PCSCS_BIT_TQ];
		ctl_next[2] = sdEff;
		ctl_next[3] = cfg_reg[`PCSCS_BIT_FIBER];
		ctl_next[4] = cfg_reg[`PCSCS_BIT_FEFI];
		ctl_next[5] = cfg_reg[`PCSCS_BIT_LINE_BYP];
		ctl_next[6] = cfg_reg[`PCSCS_BIT_SCR_SKIP];
		ctl_next[7] = cfg_reg[`PCSCS_BIT_DESCR_SKIP];
		ctl_next[8] = cfg_reg[`PCSCS_BIT_DESCRAMBLER_TIMEOUT_SELECT];
		ctl_next[9] = (link_next != pcscs_pkg::PCSCS_LINK_DOWN);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			ctl_reg <= 10'h000;
		else if (clkEn)
			ctl_reg <= ctl_next;
	end

	assign rxClkFreeRun = ctl_reg[0];
	assign trueQuietTxEnable = ctl_reg[1];
	assign signalDetect = ctl_reg[2];
	assign fiberModeEnable = ctl_reg[3];
	assign farEndFaultEnable = ctl_reg[4];
	assign lineCodeBypass = ctl_reg[5];
	assign scramblerSkipEnable = ctl_reg[6];
	assign descramblerSkipEnable = ctl_reg[7];
	assign descramblerLongTimeout = ctl_reg[8];
	assign link100Good = ctl_reg[9];
endmodule : pcs_config_status_control

// ==== pcscs_cfg_monitor.sv ====
/* Port checker for the coding-sublayer register bank.
 * Assumes a bind onto the top module and a single clock domain. */
`timescale 1ns/1ns
module pcscs_cfg_monitor (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clkEn,
	input wire logic [1:0] pageSel,
	input wire logic [4:0] regAddr,
	input wire logic wrStrobe,
	input wire logic [15:0] wrData,
	input wire logic [15:0] rdData,
	input wire logic signalLevelPin,
	input wire logic rxClkFreeRun,
	input wire logic trueQuietTxEnable,
	input wire logic signalDetect,
	input wire logic fiberModeEnable,
	input wire logic farEndFaultEnable,
	input wire logic lineCodeBypass,
	input wire logic scramblerSkipEnable,
	input wire logic descramblerSkipEnable,
	input wire logic descramblerLongTimeout,
	input wire logic link100Good
);
	// ****************************************
	// Properties
	// ****************************************
	// Address decode seen by the host
	wire logic hit = pageSel == 2'h0 && regAddr == 5'h16;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// Line quiet and no forcing long enough to pass the pin synchronisers
	sequence quietLine;
		(hit && clkEn && !rdData[5] && !rdData[9] && !signalLevelPin) [*5];
	endsequence
	chk_rsvd_read_zero: assert property (rdData[15:12] == 4'h0 && !rdData[4])
		else $error("reserved bits read nonzero");
	chk_miss_read_zero: assert property (!hit |-> rdData == 16'h0000)
		else $error("read data outside the register");
	chk_write_lands: assert property (hit && clkEn && wrStrobe ##1 hit |->
		rdData == ($past(wrData) & 16'h0fef)) else $error("write not taken");
	chk_clk_quiet: assert property (hit && clkEn |=> rxClkFreeRun == $past(rdData[11])
		&& trueQuietTxEnable == $past(rdData[10])) else $error("clock or quiet copy");
	chk_time_fiber: assert property (hit && clkEn |=> descramblerLongTimeout ==
		$past(rdData[7]) && fiberModeEnable == $past(rdData[6])) else $error("timeout copy");
	chk_fault_nrzi: assert property (hit && clkEn |=> farEndFaultEnable ==
		$past(rdData[3]) && lineCodeBypass == $past(rdData[2])) else $error("fault copy");
	chk_skip_copy: assert property (hit && clkEn |=> scramblerSkipEnable ==
		$past(rdData[1]) && descramblerSkipEnable == $past(rdData[0])) else $error("skip copy");
	chk_sd_force: assert property (hit && clkEn && rdData[9] |=> signalDetect)
		else $error("signal detect not forced");
	chk_force_link: assert property (hit && clkEn && rdData[5] |-> ##[1:2] link100Good)
		else $error("forced link not reported");
	chk_level_drop: assert property (quietLine |-> !link100Good)
		else $error("link kept without signal");
endmodule : pcscs_cfg_monitor
bind pcs_config_status_control pcscs_cfg_monitor mon (.clk, .resetn, .clkEn, .pageSel,
	.regAddr, .wrStrobe, .wrData, .rdData, .signalLevelPin, .rxClkFreeRun,
	.trueQuietTxEnable, .signalDetect, .fiberModeEnable, .farEndFaultEnable,
	.lineCodeBypass, .scramblerSkipEnable, .descramblerSkipEnable,
	.descramblerLongTimeout, .link100Good);

// ==== pcscs_consts.svh ====
/*
 * Constants for the 100 Mb/s coding-sublayer configuration register bank:
 * register address, page, field positions, reset values and timeouts.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef PCSCS_CONSTS_SVH
`define PCSCS_CONSTS_SVH

// ****************************************
// Register address and page
// ****************************************
`define PCSCS_REG_ADDR 5'h16
`define PCSCS_PAGE_EXT0 2'h0
`define PCSCS_PAGED_LO 5'h14

// ****************************************
// Field positions
// ****************************************
`define PCSCS_BIT_FREE_CLK 11
`define PCSCS_BIT_TQ 10
`define PCSCS_BIT_SD_FORCE 9
`define PCSCS_BIT_SD_POLICY 8
`define PCSCS_BIT_DESCRAMBLER_TIMEOUT_SELECT 7
`define PCSCS_BIT_FIBER 6
`define PCSCS_BIT_FORCE_OK 5
`define PCSCS_BIT_FEFI 3
`define PCSCS_BIT_LINE_BYP 2
`define PCSCS_BIT_SCR_SKIP 1
`define PCSCS_BIT_DESCR_SKIP 0

// ****************************************
// Write mask and reset values
// ****************************************
`define PCSCS_WR_MASK 16'h0fef
`define PCSCS_RESET_BASE 16'h0100
`define PCSCS_STRAP_BITS 16'h004b

// ****************************************
// Strap load timing after reset release
// ****************************************
`define PCSCS_LOAD_AT 2'h2
`define PCSCS_LOAD_DONE 2'h3
`define PCSCS_LOAD_STEP 2'h1

// ****************************************
// Descrambler loss-of-sync timeouts
// ****************************************
`define PCSCS_TIMEOUT_LONG_US 2000
`define PCSCS_TIMEOUT_SHORT_US 722
`define PCSCS_CLK_MHZ 100

`endif

// ==== pcscs_host.sv ====
/* Management host model: selects page and address, pulses writes.
 * Assumes the bench calls its tasks; drives on the falling edge. */
`timescale 1ns/1ns
module pcscs_host (
	input wire logic clk,
	output logic [1:0] pageSel,
	output logic [4:0] regAddr,
	output logic wrStrobe,
	output logic [15:0] wrData
);
	// ****************************************
	// Access tasks
	// ****************************************
	initial begin
		pageSel = 2'h0;
		regAddr = 5'h16;
		wrStrobe = 1'b0;
		wrData = 16'h0000;
	end
	// Point at a register for reads
	task point(input logic [1:0] p, input logic [4:0] a);
		@(negedge clk);
		pageSel = p;
		regAddr = a;
	endtask : point
	// One-cycle write, then back to page 0 so the register stays reachable
	task write(input logic [1:0] p, input logic [4:0] a, input logic [15:0] d);
		@(negedge clk);
		pageSel = p;
		regAddr = a;
		wrData = d;
		wrStrobe = 1'b1;
		@(negedge clk);
		wrStrobe = 1'b0;
		pageSel = 2'h0;
		regAddr = 5'h16;
		wrData = ~d; // Released data never shows the old word
	endtask : write
endmodule : pcscs_host

// ==== pcscs_pkg.sv ====
/*
 * Types shared by the coding-sublayer configuration block.
 * Assumes the constants header is available by bare name.
 */
`include "pcscs_consts.svh"

package pcscs_pkg;
	// Link qualification states, one-hot
	typedef enum logic [2:0] {
		PCSCS_LINK_DOWN = 3'h1,
		PCSCS_LINK_UP = 3'h2,
		PCSCS_LINK_FORCED = 3'h4
	} pcscs_link_t;
endpackage : pcscs_pkg

// ==== pcscs_sync_timer.sv ====
/*
 * Descrambler loss-of-sync watchdog: counts cycles since the last valid
 * lock indication and flags loss once the selected timeout is reached.
 * Assumes lock pulses arrive on the same clock as clk.
 */
`timescale 1ns/1ns
`include "pcscs_consts.svh"

module pcscs_sync_timer #(
	parameter int LONG_CYCLES = `PCSCS_TIMEOUT_LONG_US * `PCSCS_CLK_MHZ,
	parameter int SHORT_CYCLES = `PCSCS_TIMEOUT_SHORT_US * `PCSCS_CLK_MHZ
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clkEn,
	input wire logic longSel,
	input wire logic syncSeen,
	output logic syncLost
);
	localparam int CW = $clog2(LONG_CYCLES + 1);

	initial begin
		if (SHORT_CYCLES < 1 || LONG_CYCLES < SHORT_CYCLES)
			$error("pcscs_sync_timer: timeouts must be positive and ordered");
	end

	logic [CW-1:0] count_reg, count_next;
	logic lost_reg, lost_next;
	logic [CW-1:0] limit;

	// Limit follows the select live, so a change takes effect mid-count
	always_comb begin
		limit = longSel ? CW'(LONG_CYCLES) : CW'(SHORT_CYCLES);
		count_next = count_reg;
		lost_next = lost_reg;
		if (syncSeen) begin
			count_next = '0;
			lost_next = 1'b0;
		end else if (count_reg >= limit) begin
			lost_next = 1'b1;
		end else begin
			count_next = count_reg + CW'(1);
		end
	end

	// Starts out of sync: lock must be shown before the link may rise, unless force-good or descrambler skip is set
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count_reg <= '0;
			lost_reg <= 1'b1;
		end else if (clkEn) begin
			count_reg <= count_next;
			lost_reg <= lost_next;
		end
	end

	assign syncLost = lost_reg;
endmodule : pcscs_sync_timer

// ==== test_pcs_config_status_control.sv ====
/* Self-checking bench for the coding-sublayer register bank.
 * Assumes the host model and the bound checker are compiled first. */
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
	$display("CHECK FAILED %0t got %h want %h", $time, a, e); end end
module test_pcs_config_status_control;
	// ****************************************
	// Bench
	// ****************************************
	logic clk = 1'b0, resetn = 1'b0, clkEn = 1'b1, strap = 1'b0, level = 1'b0, lock = 1'b0;
	logic [1:0] pageSel;
	logic [4:0] regAddr;
	logic wrStrobe;
	logic [15:0] wrData, rdData, d;
	logic [9:0] outs;
	int mismatches = 0, cmp_count = 0, cycles = 0;
	always #5 clk = ~clk;
	pcscs_host host (.clk(clk), .pageSel(pageSel), .regAddr(regAddr), .wrStrobe(wrStrobe),
		.wrData(wrData));
	// Short watchdog limits keep the link runs brief
	pcs_config_status_control #(.LONG_CYCLES(20), .SHORT_CYCLES(8)) dut (.clk(clk),
		.resetn(resetn), .clkEn(clkEn), .pageSel(pageSel), .regAddr(regAddr),
		.wrStrobe(wrStrobe), .wrData(wrData), .rdData(rdData), .fiberStrap(strap),
		.signalLevelPin(level), .descramblerLockPin(lock),
		.rxClkFreeRun(outs[9]), .trueQuietTxEnable(outs[8]), .signalDetect(outs[7]),
		.descramblerLongTimeout(outs[6]), .fiberModeEnable(outs[5]),
		.farEndFaultEnable(outs[4]), .lineCodeBypass(outs[3]),
		.scramblerSkipEnable(outs[2]), .descramblerSkipEnable(outs[1]),
		.link100Good(outs[0]));
	// Expected control outputs for a register word, line quiet
	function automatic logic [8:0] expOuts(input logic [15:0] v);
		return {v[11], v[10], v[9], v[7], v[6], v[3], v[2], v[1], v[0]};
	endfunction : expOuts
	task wrap_up;
		if (mismatches == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	task idle(input int n);
		repeat (n) @(negedge clk);
	endtask : idle
	task rd(input logic [1:0] p, input logic [15:0] e);
		host.point(p, 5'h16);
		#1;
		`CHK(rdData, e)
	endtask : rd
	// Strap is sampled after release, so give it time before reading
	task doReset(input logic s);
		@(negedge clk);
		resetn = 1'b0;
		strap = s;
		idle(4);
		resetn = 1'b1;
		idle(8);
	endtask : doReset
	// Pulse the lock pin long enough to cross the synchroniser
	task lockPulse;
		lock = 1'b1;
		idle(3);
		lock = 1'b0;
		idle(4);
	endtask : lockPulse
	// Hang guard well above the planned run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			wrap_up();
		end
	end
	initial begin
		d = $urandom(19);
		doReset(1'b0);
		rd(2'h0, 16'h0100);
		doReset(1'b1);
		rd(2'h0, 16'h014b);
		for (int i = 0; i < 24; i++) begin
			d = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
			host.write(2'h0, 5'h16, d);
			rd(2'h0, d & 16'h0fef);
			`CHK(outs[9:1], expOuts(d & 16'h0fef))
		end
		host.write(2'h1, 5'h16, 16'h0fff);
		host.write(2'h0, 5'h15, 16'h0fff);
		rd(2'h2, 16'h0000);
		rd(2'h0, d & 16'h0fef);
		clkEn = 1'b0;
		host.write(2'h0, 5'h16, 16'h0fff);
		clkEn = 1'b1;
		rd(2'h0, d & 16'h0fef);
		// Hold policy: lock loss alone keeps the link
		host.write(2'h0, 5'h16, 16'h0100);
		level = 1'b1;
		lockPulse();
		`CHK(outs[0], 1'b1)
		idle(30);
		`CHK(outs[0], 1'b1)
		// Strict policy with the long and then the short timeout
		host.write(2'h0, 5'h16, 16'h0080);
		lockPulse();
		`CHK(outs[0], 1'b1)
		idle(10);
		`CHK(outs[0], 1'b1)
		idle(20);
		`CHK(outs[0], 1'b0)
		host.write(2'h0, 5'h16, 16'h0000);
		lockPulse();
		`CHK(outs[0], 1'b1)
		idle(10);
		`CHK(outs[0], 1'b0)
		level = 1'b0;
		host.write(2'h0, 5'h16, 16'h0020);
		idle(2);
		`CHK(outs[0], 1'b1)
		host.write(2'h0, 5'h16, 16'h0200);
		idle(2);
		`CHK(outs[0], 1'b0)
		`CHK(outs[7], 1'b1)
		wrap_up();
	end
endmodule : test_pcs_config_status_control
